// *** tsa_host.sv ***
// serial bus host model making the link clock and data
module tsa_host (
  output logic scl,
  output logic sda_o,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 50;
  initial begin
    scl = 1'b1;  // clock stands high outside frames
    sda_o = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_o = 1'b1;
    // extra 5 ns keeps every pin change off the bench clock edge
    #(3*Q+5) scl = 1'b1;
    #(2*Q) sda_o = 1'b0;
    #(2*Q) scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #Q sda_o = 1'b0;
    #(2*Q) scl = 1'b1;
    #(2*Q) sda_o = 1'b1;
    #(2*Q);
  endtask
  // one bit: data changes while clock low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// *** tsa_pkg.sv ***
// shared constants and types of the thermal sensor alarm block
package tsa_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CONV_RATE_HZ = 8;
  localparam int unsigned CONV_PERIOD_NS = 1_000_000_000 / CONV_RATE_HZ;
  localparam int unsigned CONV_CYCLES_DEF = CONV_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam logic [19:0] TOUT_US_RST = 20'h0_61A8;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int unsigned TEMP_W = 11;
  localparam int unsigned AXI_AW = 5;

  // ----------------------------------------------------------------
  // register indices, byte address is index times four
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_CFG = 3'h1;
  localparam logic [2:0] IDX_UPPER = 3'h2;
  localparam logic [2:0] IDX_LOWER = 3'h3;
  localparam logic [2:0] IDX_CRIT = 3'h4;
  localparam logic [2:0] IDX_TEMP = 3'h5;
  localparam logic [2:0] IDX_TOUT = 3'h6;
  localparam logic [2:0] IDX_STAT = 3'h7;

  // ----------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_MODE = 0;
  localparam int unsigned CFG_POL = 1;
  localparam int unsigned CFG_CRIT_ONLY = 2;
  localparam int unsigned CFG_EN = 3;
  localparam int unsigned CFG_STAT = 4;
  localparam int unsigned CFG_CLR = 5;
  localparam int unsigned CFG_WLOCK = 6;
  localparam int unsigned CFG_CLOCK = 7;
  localparam int unsigned CFG_SHDN = 8;
  localparam int unsigned CFG_HYS_LO = 9;
  localparam int unsigned CFG_HYS_HI = 10;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [TEMP_W-1:0] THR_RST = 11'h000;
  localparam logic [TEMP_W-1:0] TEMP_RST = 11'h000;
  localparam logic [11:0] HYS_0C0 = 12'h000;
  localparam logic [11:0] HYS_1C5 = 12'h00C;
  localparam logic [11:0] HYS_3C0 = 12'h018;
  localparam logic [11:0] HYS_6C0 = 12'h030;
  localparam logic [3:0] ADDR_FIXED = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // serial slave states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } tsa_i2c_st_t;

endpackage

// *** tsa_sync.sv ***
// two flip-flop synchroniser for pin inputs
module tsa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// *** tsa_top.sv ***
// thermal sensor alarm: conversion latch, alarm logic, serial slave, axi4-lite registers
module tsa_top #(
  parameter int unsigned CONV_CYCLES = tsa_pkg::CONV_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [tsa_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tsa_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [tsa_pkg::TEMP_W-1:0] temp_sample,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe_n,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  output logic alarm_pin_out,
  output logic alarm_pin_oe_n
);
  import tsa_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] conv_cnt_q;
  logic [TEMP_W-1:0] temp_q, upper_q, lower_q, crit_lim_q;
  logic mode_q, pol_q, crit_only_q, alarm_output_enable_q, wlock_q, clock_q, shdn_q;
  logic [1:0] hys_q;
  logic [19:0] tout_q, tcnt_q;
  logic [5:0] us_cnt_q;
  logic crit_q, win_q, int_q, alarm_q, alarm_oe_n_q, zero_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [4:0] sy;
  logic scl_d_q, sda_d_q, sda_oe_n_q, ack_on_q, rw_q, rd_lo_q, i2c_pend_q;
  logic [2:0] bit_q, apins_q, ptr_q;
  logic [1:0] bidx_q;
  logic [7:0] sh_q, wrhi_q;
  logic [15:0] rdbuf_q, i2c_dat_q;
  tsa_i2c_st_t st_q;

  // ----------------------------------------------------------------
  // register read view
  // ----------------------------------------------------------------
  wire above_win;
  wire below_win;
  wire [31:0] cfg_rd = {16'h0000, 5'h00, hys_q, shdn_q, clock_q, wlock_q, 1'h0, alarm_q,
                        alarm_output_enable_q, crit_only_q, pol_q, mode_q};
  wire [31:0] temp_rd = {16'h0000, crit_q, above_win, below_win, 2'h0, temp_q};
  wire [31:0] stat_rd = {16'h0000, 8'h00, st_q, apins_q};

  // one word per index; a net array keeps every reader sensitive to the contents
  wire [31:0] reg_view [8];
  assign reg_view[0] = 32'h0000_0000;
  assign reg_view[IDX_CFG] = cfg_rd;
  assign reg_view[IDX_UPPER] = {21'h00_0000, upper_q};
  assign reg_view[IDX_LOWER] = {21'h00_0000, lower_q};
  assign reg_view[IDX_CRIT] = {21'h00_0000, crit_lim_q};
  assign reg_view[IDX_TEMP] = temp_rd;
  assign reg_view[IDX_TOUT] = {12'h000, tout_q};
  assign reg_view[IDX_STAT] = stat_rd;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  wire [2:0] aw_idx = s_axi_awaddr[4:2];
  wire [2:0] ar_idx = s_axi_araddr[4:2];
  wire aw_take = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
  wire ar_take = s_axi_arvalid & ~arready_q & ~rvalid_q;
  wire axi_wr = awready_q;
  wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] axi_wdat = (reg_view[aw_idx] & ~strb_mask) | (s_axi_wdata & strb_mask);

  // address and data accepted together, one-cycle ready pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_q <= 1'h0;
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      awready_q <= aw_take;
      if (axi_wr) begin
        bvalid_q <= 1'h1;
        bresp_q <= (aw_idx == 3'h0) ? RESP_DECERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'h0;
      end
    end
  end

  // read channel, data registered at the address handshake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_q <= 1'h0;
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ar_take;
      if (arready_q) begin
        rvalid_q <= 1'h1;
        rdata_q <= reg_view[ar_idx];
        rresp_q <= (ar_idx == 3'h0) ? RESP_DECERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared write port, axi first, serial write waits one cycle
  // ----------------------------------------------------------------
  wire wr_go = axi_wr | i2c_pend_q;
  wire [2:0] wr_idx = axi_wr ? aw_idx : ptr_q;
  wire [31:0] wr_dat = axi_wr ? axi_wdat : {16'h0000, i2c_dat_q};
  wire wr_cfg = wr_go & (wr_idx == IDX_CFG);
  wire clr_pulse = wr_cfg & wr_dat[CFG_CLR];

  // configuration word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 1'h0;
      pol_q <= 1'h0;
      crit_only_q <= 1'h0;
      alarm_output_enable_q <= 1'h0;
      wlock_q <= 1'h0;
      clock_q <= 1'h0;
      shdn_q <= 1'h0;
      hys_q <= 2'h0;
    end else if (wr_cfg) begin
      if (!alarm_output_enable_q) begin
        mode_q <= wr_dat[CFG_MODE];
        crit_only_q <= wr_dat[CFG_CRIT_ONLY];
      end
      pol_q <= wr_dat[CFG_POL];
      alarm_output_enable_q <= wr_dat[CFG_EN];
      wlock_q <= wlock_q | wr_dat[CFG_WLOCK];
      clock_q <= clock_q | wr_dat[CFG_CLOCK];
      shdn_q <= wr_dat[CFG_SHDN];
      hys_q <= wr_dat[CFG_HYS_HI:CFG_HYS_LO];
    end
  end

  // thresholds guarded by the locks, bus timeout always writable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upper_q <= THR_RST;
      lower_q <= THR_RST;
      crit_lim_q <= THR_RST;
      tout_q <= TOUT_US_RST;
    end else if (wr_go) begin
      if (wr_idx == IDX_UPPER && !wlock_q) upper_q <= wr_dat[TEMP_W-1:0];
      if (wr_idx == IDX_LOWER && !wlock_q) lower_q <= wr_dat[TEMP_W-1:0];
      if (wr_idx == IDX_CRIT && !clock_q) crit_lim_q <= wr_dat[TEMP_W-1:0];
      if (wr_idx == IDX_TOUT) tout_q <= wr_dat[19:0];
    end
  end

  // ----------------------------------------------------------------
  // conversion timer, stopped in shutdown
  // ----------------------------------------------------------------
  wire conv_tick = (conv_cnt_q == CONV_CYCLES - 1) & ~shdn_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt_q <= 32'h0000_0000;
      temp_q <= TEMP_RST;
    end else if (!shdn_q) begin
      conv_cnt_q <= conv_tick ? 32'h0000_0000 : conv_cnt_q + 32'h0000_0001;
      if (conv_tick) temp_q <= temp_sample;
    end
  end

  // ----------------------------------------------------------------
  // alarm comparisons, signed with one guard bit
  // ----------------------------------------------------------------
  wire signed [11:0] t_s = {temp_q[10], temp_q};
  wire signed [11:0] u_s = {upper_q[10], upper_q};
  wire signed [11:0] l_s = {lower_q[10], lower_q};
  wire signed [11:0] c_s = {crit_lim_q[10], crit_lim_q};
  wire signed [11:0] h_s = (hys_q == 2'h0) ? HYS_0C0 : (hys_q == 2'h1) ? HYS_1C5 :
                           (hys_q == 2'h2) ? HYS_3C0 : HYS_6C0;
  wire above_crit = t_s >= c_s;
  wire crit_release = t_s < (c_s - h_s);
  assign above_win = t_s > u_s;
  assign below_win = t_s < l_s;
  wire win_inside = (t_s <= (u_s - h_s)) && (t_s >= (l_s + h_s));
  wire win_d = (above_win | below_win) ? 1'h1 : (win_inside ? 1'h0 : win_q);
  wire band_alarm = crit_only_q ? 1'h0 : (mode_q ? int_q : win_q);
  wire alarm_d = crit_q | band_alarm;
  wire drive_low = alarm_output_enable_q & (alarm_q ? ~pol_q : pol_q);

  // band states; crossing sets interrupt, set wins over clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crit_q <= 1'h0;
      win_q <= 1'h0;
      int_q <= 1'h0;
    end else begin
      if (above_crit) crit_q <= 1'h1;
      else if (crit_release) crit_q <= 1'h0;
      win_q <= win_d;
      if (win_d != win_q) int_q <= 1'h1;
      else if (clr_pulse) int_q <= 1'h0;
    end
  end

  // alarm level frozen in shutdown, open-drain pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_q <= 1'h0;
      alarm_oe_n_q <= 1'h1;
      zero_q <= 1'h0;
    end else begin
      if (!shdn_q) alarm_q <= alarm_d;
      alarm_oe_n_q <= ~drive_low;
    end
  end

  // ----------------------------------------------------------------
  // serial slave front end
  // ----------------------------------------------------------------
  // pin pull-downs on address select sit in the pad; open pins arrive as zero
  tsa_sync #(.W(5), .RST(5'h03)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({addr_select_bit2, addr_select_bit1, addr_select_bit0, sda_pin_in, scl_pin}),
    .q(sy)
  );

  wire scl_s = sy[0];
  wire sda_s = sy[1];
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire bus_stop = scl_s & scl_d_q & ~sda_d_q & sda_s;
  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  wire addr_hit = rx_byte[7:1] == {ADDR_FIXED, apins_q};
  wire byte_done = (st_q == ST_RX) & scl_rise & (bit_q == 3'h7);
  wire [15:0] rd_word = reg_view[ptr_q][15:0];
  wire us_tick = us_cnt_q == 6'(US_CYCLES - 1);
  wire tout_hit = (tout_q != 20'h0_0000) & (tcnt_q >= tout_q) & (st_q != ST_IDLE);

  // edge history, microsecond divider and low-clock timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_q <= 1'h1;
      sda_d_q <= 1'h1;
      us_cnt_q <= 6'h00;
      tcnt_q <= 20'h0_0000;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
      us_cnt_q <= us_tick ? 6'h00 : us_cnt_q + 6'h01;
      if (scl_s || st_q == ST_IDLE) tcnt_q <= 20'h0_0000;
      else if (us_tick && tcnt_q != 20'hF_FFFF) tcnt_q <= tcnt_q + 20'h0_0001;
    end
  end

  // completed write word waits for a free write port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i2c_pend_q <= 1'h0;
      i2c_dat_q <= 16'h0000;
    end else if (byte_done && bidx_q == 2'h3 && !rw_q) begin
      i2c_pend_q <= 1'h1;
      i2c_dat_q <= {wrhi_q, rx_byte};
    end else if (!axi_wr) begin
      i2c_pend_q <= 1'h0;
    end
  end

  // byte engine: address, pointer, data high, data low; sda only ever pulled low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      bidx_q <= 2'h0;
      sh_q <= 8'h00;
      apins_q <= 3'h0;
      ptr_q <= 3'h0;
      wrhi_q <= 8'h00;
      rdbuf_q <= 16'h0000;
      rw_q <= 1'h0;
      ack_on_q <= 1'h0;
      rd_lo_q <= 1'h0;
      sda_oe_n_q <= 1'h1;
    end else if (bus_start) begin
      st_q <= ST_RX;
      bit_q <= 3'h0;
      bidx_q <= 2'h0;
      apins_q <= sy[4:2];
      sda_oe_n_q <= 1'h1;
    end else if (bus_stop || tout_hit) begin
      st_q <= ST_IDLE;
      sda_oe_n_q <= 1'h1;
    end else begin
      case (st_q)
        ST_RX: begin
          if (scl_rise) begin
            sh_q <= rx_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              ack_on_q <= 1'h0;
              st_q <= (bidx_q == 2'h0 && !addr_hit) ? ST_IDLE : ST_ACK;
              if (bidx_q == 2'h0) rw_q <= rx_byte[0];
              if (bidx_q == 2'h1) ptr_q <= rx_byte[2:0];
              if (bidx_q == 2'h2) wrhi_q <= rx_byte;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall && !ack_on_q) begin
            sda_oe_n_q <= 1'h0;
            ack_on_q <= 1'h1;
          end else if (scl_fall) begin
            ack_on_q <= 1'h0;
            bit_q <= 3'h0;
            bidx_q <= (bidx_q == 2'h3) ? 2'h2 : bidx_q + 2'h1;
            if (rw_q) begin
              st_q <= ST_TX;
              rdbuf_q <= rd_word;
              sda_oe_n_q <= rd_word[15];
              sh_q <= {rd_word[14:8], 1'h1};
              rd_lo_q <= 1'h1;
            end else begin
              st_q <= ST_RX;
              sda_oe_n_q <= 1'h1;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) st_q <= ST_MACK;
          end else if (scl_fall) begin
            sda_oe_n_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'h1};
          end
        end
        ST_MACK: begin
          if (scl_fall) begin
            sda_oe_n_q <= 1'h1;
          end else if (scl_rise && sda_s) begin
            st_q <= ST_IDLE;
          end else if (scl_rise) begin
            st_q <= ST_TX;
            bit_q <= 3'h0;
            sh_q <= rd_lo_q ? rdbuf_q[7:0] : rdbuf_q[15:8];
            rd_lo_q <= ~rd_lo_q;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops; scl is input only
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign sda_pin_out = zero_q;
  assign sda_pin_oe_n = sda_oe_n_q;
  assign alarm_pin_out = zero_q;
  assign alarm_pin_oe_n = alarm_oe_n_q;

endmodule

// *** tsa_top_properties.sv ***
// port properties of the thermal sensor alarm block
module tsa_top_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [tsa_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic [tsa_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_pin_out,
  input wire logic alarm_pin_out,
  input wire logic alarm_pin_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import tsa_pkg::*;
  logic en_q;
  logic rd_cfg_q;
  // config write and read decode
  wire wr_cfg = s_axi_awready && s_axi_awaddr[4:2] == IDX_CFG && s_axi_wstrb[0];
  wire ar_cfg = s_axi_araddr[4:2] == IDX_CFG;
  // shadow of output enable and of a pending config read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 1'b0;
      rd_cfg_q <= 1'b0;
    end else begin
      if (wr_cfg) en_q <= s_axi_wdata[CFG_EN];
      if (s_axi_arready) rd_cfg_q <= ar_cfg;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // bus requests seen for the first time
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_awready ##1 s_axi_bvalid) else $error("write late");
  a_read_answer: assert property (s_rd_take |=> s_axi_arready ##1 s_axi_rvalid) else $error("read late");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  a_clear_reads_zero: assert property (s_axi_rvalid && rd_cfg_q |-> !s_axi_rdata[CFG_CLR]) else $error("clr set");
  a_alarm_off: assert property (!en_q [*4] |-> alarm_pin_oe_n) else $error("alarm driven");
  a_alarm_drain: assert property (alarm_pin_out == 1'b0) else $error("alarm drives high");
  a_sda_drain: assert property (sda_pin_out == 1'b0) else $error("sda drives high");
endmodule

bind tsa_top tsa_top_properties tsa_top_properties_i (.*);

// *** tsa_top_tb.sv ***
// self-checking bench of the thermal sensor alarm block
module tsa_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsa_pkg::*;
  localparam int unsigned CONV = 64;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [TEMP_W-1:0] temp_sample = '0;
  logic addr_select_bit0 = 1'b0, addr_select_bit1 = 1'b0, addr_select_bit2 = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata;
  logic scl_pin, sda_o, sda_pin_in, sda_pin_out, sda_pin_oe_n, alarm_pin_out, alarm_pin_oe_n, ack;
  logic [7:0] hb, lb;
  int errors = 0, tests_run = 0;
  assign sda_pin_in = sda_o & sda_pin_oe_n;  // pulled-up shared line
  always #12.5 clk = ~clk;
  tsa_top #(.CONV_CYCLES(CONV)) tsa_top_i (.*);
  tsa_host tsa_host_i (.scl(scl_pin), .sda_o(sda_o), .sda(sda_pin_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bus write: valids held until taken, bready until answer
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_awready !== 1'b1) @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  // bus read compared with an expected word
  task automatic rdc(input logic [AXI_AW-1:0] a, input logic [31:0] exp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_arready !== 1'b1) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b0;
    rsp = s_axi_rresp;
    chk(s_axi_rdata, exp);
  endtask
  task automatic pin(input logic exp);
    cyc(4);
    chk(32'(alarm_pin_oe_n), 32'(exp));
  endtask
  task automatic t_reset();
    rdc(5'h04, 32'h0000_0010);
    rdc(5'h18, 32'h0000_61A8);
    rdc(5'h00, 32'h0);
    chk(32'(rsp), 32'(RESP_DECERR));
    wr(5'h00, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'(RESP_DECERR));
    pin(1'b1);
  endtask
  task automatic t_conv();
    @(posedge clk);
    temp_sample <= 11'h080;
    cyc(CONV + 4);
    rdc(5'h14, 32'h0000_C080);
  endtask
  task automatic t_mode();
    wr(5'h10, 32'h0000_03FF);
    chk(32'(rsp), 32'(RESP_OKAY));
    wr(5'h08, 32'h0000_0100);
    wr(5'h04, 32'h0000_0029);
    wr(5'h04, 32'h0000_000C);
    rdc(5'h04, 32'h0000_0009);
    wr(5'h04, 32'h0);
    wr(5'h04, 32'h0000_000C);
    rdc(5'h04, 32'h0000_000C);
    wr(5'h04, 32'h0);
  endtask
  task automatic t_comp();
    wr(5'h04, 32'h0000_000A);
    pin(1'b0);
    rdc(5'h14, 32'h0000_0080);
    pin(1'b0);
    wr(5'h08, 32'h0000_0040);
    pin(1'b1);
    wr(5'h04, 32'h0);
    pin(1'b1);
    wr(5'h04, 32'h0000_0008);
    pin(1'b0);
    wr(5'h04, 32'h0);
  endtask
  task automatic t_int();
    wr(5'h04, 32'h0000_0029);
    pin(1'b1);
    wr(5'h08, 32'h0000_0100);
    pin(1'b0);
    rdc(5'h04, 32'h0000_0019);
    wr(5'h04, 32'h0000_0029);
    pin(1'b1);
  endtask
  task automatic t_serial();
    @(posedge clk);
    addr_select_bit0 <= 1'b1;
    addr_select_bit2 <= 1'b1;
    cyc(4);
    tsa_host_i.start();
    tsa_host_i.put_byte(8'h3A, ack);
    chk(32'(ack), 32'h1);
    tsa_host_i.put_byte(8'h06, ack);
    tsa_host_i.put_byte(8'h00, ack);
    tsa_host_i.put_byte(8'h02, ack);
    tsa_host_i.stop();
    rdc(5'h18, 32'h0000_0002);
    tsa_host_i.start();
    tsa_host_i.put_byte(8'h3A, ack);
    tsa_host_i.put_byte(8'h06, ack);
    tsa_host_i.start();
    tsa_host_i.put_byte(8'h3B, ack);
    tsa_host_i.get_byte(1'b0, hb);
    tsa_host_i.get_byte(1'b1, lb);
    tsa_host_i.stop();
    chk({16'h0, hb, lb}, 32'h0000_0002);
    rdc(5'h1C, 32'h0000_000D);
    tsa_host_i.start();
    tsa_host_i.put_byte(8'h30, ack);
    chk(32'(ack), 32'h0);
    tsa_host_i.stop();
    @(posedge clk);
    addr_select_bit0 <= 1'b0;
    addr_select_bit2 <= 1'b0;
    cyc(4);
    tsa_host_i.start();
    tsa_host_i.put_byte(8'h30, ack);
    chk(32'(ack), 32'h1);
    tsa_host_i.stop();
    rdc(5'h1C, 32'h0000_0008);
  endtask
  // host stalls the clock low while the device drives data
  task automatic t_tout();
    tsa_host_i.start();
    tsa_host_i.put_byte(8'h31, ack);
    #200;
    chk(32'(sda_pin_oe_n), 32'h0);
    #5000;
    chk(32'(sda_pin_oe_n), 32'h1);
    tsa_host_i.stop();
  endtask
  task automatic t_crit();
    wr(5'h04, 32'h0000_0629);
    wr(5'h10, 32'h0000_0080);
    pin(1'b0);
    wr(5'h04, 32'h0000_0629);
    pin(1'b0);
    wr(5'h10, 32'h0000_00A0);
    pin(1'b0);
    wr(5'h04, 32'h0000_0729);
    wr(5'h10, 32'h0000_00B1);
    pin(1'b0);
    wr(5'h04, 32'h0000_06E9);
    pin(1'b1);
    wr(5'h10, 32'h0000_07FF);
    wr(5'h08, 32'h0000_07FF);
    rdc(5'h10, 32'h0000_00B1);
    rdc(5'h08, 32'h0000_0100);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_conv();
    t_mode();
    t_comp();
    t_int();
    t_serial();
    t_tout();
    t_crit();
    wrap_up();
  end
  // watchdog against a hung handshake
  initial begin
    #1_000_000;
    errors++;
    wrap_up();
  end
endmodule
